// [common/touch_irq_pkg.sv]
// Constants and carrier types of the touch sensing interrupt logic.
// Assumes an AXI4-Lite master with 32-bit data and a single clock.
package touch_irq_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int STAGES = 8;        // Conversion stages
   localparam int REG_W = 16;        // Width of each device register
   localparam int ADDR_W = 8;        // Byte address width
   localparam int IDX_W = 6;         // Register index width
   localparam int IDX_LSB = 2;       // Byte address is index times four
   localparam int EV_W = 2;          // Event class count

   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [IDX_W-1:0] IDX_LOW_EN = 6'h05;
   localparam logic [IDX_W-1:0] IDX_HIGH_EN = 6'h06;
   localparam logic [IDX_W-1:0] IDX_DONE_EN = 6'h07;
   localparam logic [IDX_W-1:0] IDX_LOW_FLAGS = 6'h08;
   localparam logic [IDX_W-1:0] IDX_HIGH_FLAGS = 6'h09;
   localparam logic [IDX_W-1:0] IDX_DONE_FLAGS = 6'h0A;
   localparam logic [IDX_W-1:0] IDX_EV_FLAGS = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_EV_MASK = 6'h0C;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int EV_DONE = 0;       // Conversion complete event bit
   localparam int EV_THR = 1;        // Threshold change event bit
   localparam logic [STAGES-1:0] EN_RESET = 8'h00;
   localparam logic [STAGES-1:0] FLAGS_RESET = 8'h00;
   localparam logic [EV_W-1:0] EV_FLAGS_RESET = 2'h0;
   localparam logic [EV_W-1:0] EV_MASK_RESET = 2'h3;

   // ----------------------------------------
   // Bus responses
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Read channel states, one-hot
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;

   // Master to slave signals
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_t;

   // Slave to master signals
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

endpackage

// [design/touch_sense_irq_logic.sv]
// Interrupt logic of a capacitance touch controller, with its
// per-stage enable and status registers behind an AXI4-Lite slave.
// Assumes stage done pulses and threshold activity levels come from
// logic on aclk; the request pin is resolved by the surroundings.
//
// Notes on behaviour
// - Request pin: active low, open drain
// - Two event classes, each with enable, status
// - Done status read clears, releases line at address
// - Enabled stage completion pulls request line low
// - Done enable: one bit per stage
// - Done status bit set per fired stage
// - Done bit stays set until the done status is read
// - Touch and release each raise a request
// - Per-stage low and high threshold enables
// - Per-stage low and high status readable
// - Threshold request held until both read
// - Any enabled threshold bit change requests
// - Threshold status reads show live activity
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps

module touch_sense_irq_logic
   import touch_irq_pkg::*;
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Register bus
   input wire axil_req_t axil_req,
   output axil_rsp_t axil_rsp,
   // Conversion and threshold inputs
   input wire logic [STAGES-1:0] stage_done,
   input wire logic [STAGES-1:0] low_active,
   input wire logic [STAGES-1:0] high_active,
   // Request pin, open drain
   output logic irq_n_out,
   output logic irq_n_oe
);

   // ----------------------------------------
   // State
   // ----------------------------------------

   // All state of the block in one record
   typedef struct packed {
      rd_state_t rd;                   // Read channel state
      axil_rsp_t rsp;                  // Bus outputs
      logic aw_held;                   // Write address captured
      logic w_held;                    // Write data captured
      logic [IDX_W-1:0] aw_idx;        // Captured write index
      logic [31:0] wdata;              // Captured write data
      logic [3:0] wstrb;               // Captured byte enables
      logic [STAGES-1:0] low_en;       // Low limit enables
      logic [STAGES-1:0] high_en;      // High limit enables
      logic [STAGES-1:0] done_en;      // Completion enables
      logic [STAGES-1:0] done_flags;   // Completion status
      logic [2*STAGES-1:0] thr_prev;   // Last enabled activity
      logic low_seen;                  // Low status read since change
      logic high_seen;                 // High status read since change
      logic [EV_W-1:0] ev_flags;       // Sticky event flags
      logic [EV_W-1:0] ev_mask;        // Event mask
      logic irq_n;                     // Pin level
      logic irq_oe;                    // Pin drive enable
   } state_t;

   state_t s_q;                        // Registered state
   state_t s_d;                        // Next state

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Index decode shared by the read and write paths
   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = 1'b0;
      case (idx)
         IDX_LOW_EN, IDX_HIGH_EN, IDX_DONE_EN: hit = 1'b1;
         IDX_LOW_FLAGS, IDX_HIGH_FLAGS: hit = 1'b1;
         IDX_DONE_FLAGS, IDX_EV_FLAGS, IDX_EV_MASK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Stage field widened to a register, upper bits zero
   function automatic logic [REG_W-1:0] widen(
      input logic [STAGES-1:0] v
   );
      return {{(REG_W-STAGES){1'b0}}, v};
   endfunction

   // ----------------------------------------
   // Combinational next state
   // ----------------------------------------

   // Handles bus handshakes, register access and event flags
   always_comb begin
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      logic [IDX_W-1:0] ar_idx;
      logic [STAGES-1:0] done_set;
      logic [2*STAGES-1:0] thr_cur;
      logic thr_change;
      logic rd_low;
      logic rd_high;
      logic rd_done;
      logic [STAGES-1:0] wbits;
      logic wr_lane;
      aw_hs = 1'b0;
      w_hs = 1'b0;
      ar_hs = 1'b0;
      ar_idx = '0;
      done_set = '0;
      thr_cur = '0;
      thr_change = 1'b0;
      rd_low = 1'b0;
      rd_high = 1'b0;
      rd_done = 1'b0;
      wbits = '0;
      wr_lane = 1'b0;
      s_d = s_q;

      // Handshakes on the three request channels
      aw_hs = axil_req.awvalid && s_q.rsp.awready;
      w_hs = axil_req.wvalid && s_q.rsp.wready;
      ar_hs = axil_req.arvalid && s_q.rsp.arready;
      ar_idx = axil_req.araddr[ADDR_W-1:IDX_LSB];

      // Write address capture
      if (aw_hs) begin
         s_d.aw_held = 1'b1;
         s_d.aw_idx = axil_req.awaddr[ADDR_W-1:IDX_LSB];
      end

      // Write data capture, in either order with the address
      if (w_hs) begin
         s_d.w_held = 1'b1;
         s_d.wdata = axil_req.wdata;
         s_d.wstrb = axil_req.wstrb;
      end

      // Write response retired
      if (s_q.rsp.bvalid && axil_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end

      // Perform the write once address and data are both held
      wbits = s_d.wdata[STAGES-1:0];
      wr_lane = s_d.wstrb[0];
      if (s_d.aw_held && s_d.w_held && !s_d.rsp.bvalid) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = is_mapped(s_d.aw_idx) ? RESP_OKAY
                                               : RESP_SLVERR;
         if (wr_lane) begin
            case (s_d.aw_idx)
               // Threshold enables, bit n is stage n
               IDX_LOW_EN: s_d.low_en = wbits;
               IDX_HIGH_EN: s_d.high_en = wbits;
               // Completion enables, one means enabled
               IDX_DONE_EN: s_d.done_en = wbits;
               // Sticky events, a one clears its bit
               IDX_EV_FLAGS: begin
                  s_d.ev_flags = s_q.ev_flags & ~wbits[EV_W-1:0];
               end
               // Event mask, a one lets the event through
               IDX_EV_MASK: s_d.ev_mask = wbits[EV_W-1:0];
               // Status and unmapped words take no write
               default: s_d.ev_flags = s_q.ev_flags;
            endcase
         end
      end

      // Read channel
      case (s_q.rd)
         RD_IDLE: begin
            if (ar_hs) begin
               s_d.rd = RD_RESP;
               s_d.rsp.rvalid = 1'b1;
               s_d.rsp.rresp = is_mapped(ar_idx) ? RESP_OKAY
                                                 : RESP_SLVERR;
               s_d.rsp.rdata = '0;
               case (ar_idx)
                  IDX_LOW_EN: begin
                     s_d.rsp.rdata[REG_W-1:0] = widen(s_q.low_en);
                  end
                  IDX_HIGH_EN: begin
                     s_d.rsp.rdata[REG_W-1:0] = widen(s_q.high_en);
                  end
                  IDX_DONE_EN: begin
                     s_d.rsp.rdata[REG_W-1:0] = widen(s_q.done_en);
                  end
                  // Live enabled activity, not a history
                  IDX_LOW_FLAGS: begin
                     s_d.rsp.rdata[REG_W-1:0] =
                        widen(low_active & s_q.low_en);
                     rd_low = 1'b1;
                  end
                  IDX_HIGH_FLAGS: begin
                     s_d.rsp.rdata[REG_W-1:0] =
                        widen(high_active & s_q.high_en);
                     rd_high = 1'b1;
                  end
                  IDX_DONE_FLAGS: begin
                     s_d.rsp.rdata[REG_W-1:0] = widen(s_q.done_flags);
                     rd_done = 1'b1;
                  end
                  IDX_EV_FLAGS: begin
                     s_d.rsp.rdata[EV_W-1:0] = s_q.ev_flags;
                  end
                  IDX_EV_MASK: begin
                     s_d.rsp.rdata[EV_W-1:0] = s_q.ev_mask;
                  end
                  // Unmapped words read as zero
                  default: s_d.rsp.rdata = '0;
               endcase
            end
         end
         RD_RESP: begin
            // Data stands until the master takes it
            if (axil_req.rready) begin
               s_d.rd = RD_IDLE;
               s_d.rsp.rvalid = 1'b0;
            end
         end
         default: begin
            s_d.rd = RD_IDLE;
            s_d.rsp.rvalid = 1'b0;
         end
      endcase

      // Accept a new request only when its channel is free
      s_d.rsp.awready = !s_d.aw_held && !s_d.rsp.bvalid;
      s_d.rsp.wready = !s_d.w_held && !s_d.rsp.bvalid;
      s_d.rsp.arready = (s_d.rd == RD_IDLE);

      // Completion status: reading clears, a new completion wins
      done_set = stage_done & s_q.done_en;
      if (rd_done) begin
         s_d.done_flags = FLAGS_RESET;
         s_d.ev_flags[EV_DONE] = 1'b0;
      end
      s_d.done_flags = s_d.done_flags | done_set;
      if (|done_set) begin
         s_d.ev_flags[EV_DONE] = 1'b1;
      end

      // Threshold activity of enabled stages, low then high
      thr_cur = {high_active & s_q.high_en,
                 low_active & s_q.low_en};
      thr_change = (thr_cur != s_q.thr_prev);
      s_d.thr_prev = thr_cur;

      // Both threshold status words must be read to release
      if (rd_low) begin
         s_d.low_seen = 1'b1;
      end
      if (rd_high) begin
         s_d.high_seen = 1'b1;
      end
      if ((rd_low || rd_high) && s_d.low_seen && s_d.high_seen) begin
         s_d.ev_flags[EV_THR] = 1'b0;
      end

      // A change restarts the wait for both reads and wins
      if (thr_change) begin
         s_d.ev_flags[EV_THR] = 1'b1;
         s_d.low_seen = 1'b0;
         s_d.high_seen = 1'b0;
      end

      // Pin pulled low while an unmasked event stands
      s_d.irq_oe = |(s_d.ev_flags & s_d.ev_mask);
      s_d.irq_n = !s_d.irq_oe;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------

   // Synchronous reset; the clock enable freezes everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q.rd <= RD_IDLE;
         s_q.rsp <= '0;
         s_q.aw_held <= 1'b0;
         s_q.w_held <= 1'b0;
         s_q.aw_idx <= '0;
         s_q.wdata <= '0;
         s_q.wstrb <= '0;
         s_q.low_en <= EN_RESET;
         s_q.high_en <= EN_RESET;
         s_q.done_en <= EN_RESET;
         s_q.done_flags <= FLAGS_RESET;
         s_q.thr_prev <= '0;
         s_q.low_seen <= 1'b0;
         s_q.high_seen <= 1'b0;
         s_q.ev_flags <= EV_FLAGS_RESET;
         s_q.ev_mask <= EV_MASK_RESET;
         s_q.irq_n <= 1'b1;
         s_q.irq_oe <= 1'b0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs, straight from the state register
   // ----------------------------------------

   // Bus outputs
   assign axil_rsp = s_q.rsp;

   // Open-drain pin: level low and driven together
   assign irq_n_out = s_q.irq_n;
   assign irq_n_oe = s_q.irq_oe;

endmodule

// [tb/touch_irq_props.sv]
// Checker of the touch interrupt logic, watching only its ports.
// Assumes it is bound to the top module, with clk_en high in use.
`timescale 1ns/100ps

module touch_irq_props
   import touch_irq_pkg::*;
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Register bus
   input wire axil_req_t axil_req,
   input wire axil_rsp_t axil_rsp,
   // Event inputs
   input wire logic [STAGES-1:0] stage_done,
   input wire logic [STAGES-1:0] low_active,
   input wire logic [STAGES-1:0] high_active,
   // Request pin
   input wire logic irq_n_out,
   input wire logic irq_n_oe
);
   // ----------------------------------------
   // Sampling and disable
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   chk_write_answer: assert property (
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
      axil_rsp.wready |=> axil_rsp.bvalid)
      else $error("write answer late");
   chk_read_answer: assert property (
      axil_req.arvalid && axil_rsp.arready |=>
      axil_rsp.rvalid && !axil_rsp.arready)
      else $error("read answer late");
   chk_read_single: assert property (
      axil_rsp.rvalid |-> !axil_rsp.arready)
      else $error("second read accepted");
   chk_upper_zero: assert property (
      axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_unmapped_read: assert property (
      axil_req.arvalid && axil_rsp.arready &&
      (axil_req.araddr[ADDR_W-1:IDX_LSB] < IDX_LOW_EN ||
      axil_req.araddr[ADDR_W-1:IDX_LSB] > IDX_EV_MASK) |=>
      axil_rsp.rresp == RESP_SLVERR)
      else $error("unmapped read not refused");

   // ----------------------------------------
   // Request pin
   // ----------------------------------------
   chk_pin_drive: assert property (
      irq_n_out == !irq_n_oe)
      else $error("pin level and enable disagree");
   // A new request needs an event or a register write behind it
   chk_raise_cause: assert property (
      $fell(irq_n_out) |-> $past(stage_done) != 8'h00 ||
      $past(low_active) != $past(low_active, 2) ||
      $past(high_active) != $past(high_active, 2) ||
      $past(axil_req.wvalid) || $past(axil_req.wvalid, 2))
      else $error("request without cause");
   // Only a read or a write may release the line
   chk_line_hold: assert property (
      !irq_n_out && !axil_req.arvalid && !axil_req.wvalid &&
      !$past(axil_req.wvalid) |=> !irq_n_out)
      else $error("request dropped without access");
endmodule

// [tb/host_irq_model.sv]
// Host side of the request pin: pull-up and request counting.
// Assumes the device only ever drives the pin low.
`timescale 1ns/100ps

module host_irq_model (
   // Device pin
   input wire logic aclk,
   input wire logic irq_n_out,
   input wire logic irq_n_oe,
   // Host view
   output logic irq_wire,
   output int falls
);
   logic last_q; // Pin level at the previous edge

   // Open drain: low only while driven, pulled high otherwise
   assign irq_wire = irq_n_oe ? irq_n_out : 1'h1;

   // Count each falling edge as one service request
   initial begin
      falls = 0;
      last_q = 1'h1;
   end
   always @(posedge aclk) begin
      if (last_q && !irq_wire) falls <= falls + 1;
      last_q <= irq_wire;
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench of the touch interrupt logic over AXI4-Lite.
// Assumes the package, the host pin model and the checker.
`timescale 1ns/100ps

module testbench;
   import touch_irq_pkg::*;
   logic aclk, aresetn, clk_en;
   axil_req_t req;
   axil_rsp_t rsp;
   logic [STAGES-1:0] stage_done, low_active, high_active, pulse;
   logic irq_n_out, irq_n_oe, irq_wire, line_r;
   logic [31:0] d; // Last read data
   logic [1:0] r; // Last response code
   int falls, errors, total_checks, f0;

   touch_sense_irq_logic dut (.aclk(aclk), .aresetn(aresetn),
      .clk_en(clk_en), .axil_req(req), .axil_rsp(rsp),
      .stage_done(stage_done), .low_active(low_active),
      .high_active(high_active), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe));
   host_irq_model host (.aclk(aclk), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe), .irq_wire(irq_wire), .falls(falls));

   // Clock, 4 ns period
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // Write: address and data together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      ad = 1'h0;
      wd = 1'h0;
      @(posedge aclk);
      req.awaddr <= a;
      req.wdata <= v;
      req.awvalid <= 1'h1;
      req.wvalid <= 1'h1;
      req.bready <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) ad = 1'h1;
         if (req.wvalid && rsp.wready) wd = 1'h1;
         if (ad) req.awvalid <= 1'h0;
         if (wd) req.wvalid <= 1'h0;
      end
      do @(posedge aclk); while (!rsp.bvalid);
      r = rsp.bresp;
      req.bready <= 1'h0;
   endtask

   // Read; stage_done carries pulse in the address cycle
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'h1;
      req.rready <= 1'h1;
      stage_done <= pulse;
      do @(posedge aclk); while (!rsp.arready);
      req.arvalid <= 1'h0;
      stage_done <= 8'h00;
      do @(posedge aclk); while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      line_r = irq_wire;
      req.rready <= 1'h0;
   endtask

   // One-cycle done pulse and new activity, then let it settle
   task automatic drv(input logic [7:0] s, lo, hi);
      @(posedge aclk);
      stage_done <= s;
      low_active <= lo;
      high_active <= hi;
      @(posedge aclk);
      stage_done <= 8'h00;
      repeat (3) @(posedge aclk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #40000;
      errors++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      aresetn = 1'h0;
      clk_en = 1'h1;
      req = '0;
      req.wstrb = 4'hF;
      stage_done = 8'h00;
      low_active = 8'h00;
      high_active = 8'h00;
      pulse = 8'h00;
      errors = 0;
      total_checks = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 5; i < 13; i++) begin
         rd(8'(i * 4));
         chk(d, (i == 12) ? 32'h3 : 32'h0);
      end
      rd(8'h00);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(8'h3C, 32'h1);
      chk(32'(r), 32'(RESP_SLVERR));
      $display("reset test done");
      for (int i = 5; i < 8; i++) begin
         wr(8'(i * 4), 32'hFFFFFF80 + i);
         rd(8'(i * 4));
         chk(d, 32'h80 + i);
      end
      // A write without the low byte lane changes nothing
      req.wstrb <= 4'hE;
      wr(8'h1C, 32'h0);
      req.wstrb <= 4'hF;
      chk(32'(r), 32'(RESP_OKAY));
      rd(8'h1C);
      chk(d, 32'h87);
      wr(8'h28, 32'hFF);
      rd(8'h28);
      chk(d, 32'h0);
      $display("register test done");
      wr(8'h1C, 32'h80);
      drv(8'h7F, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h1);
      drv(8'h80, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h0);
      rd(8'h28);
      chk(d, 32'h80);
      chk(32'(line_r), 32'h1);
      pulse = 8'h80;
      rd(8'h28);
      pulse = 8'h00;
      chk(32'(line_r), 32'h0);
      rd(8'h28);
      chk(d, 32'h80);
      wr(8'h30, 32'h2);
      drv(8'h80, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h1);
      rd(8'h2C);
      chk(d, 32'h1);
      wr(8'h30, 32'h3);
      drv(8'h00, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h0);
      wr(8'h2C, 32'h1);
      drv(8'h00, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h1);
      rd(8'h28);
      chk(d, 32'h80);
      // A frozen block ignores a completion pulse
      @(posedge aclk);
      clk_en <= 1'h0;
      drv(8'h80, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h1);
      clk_en <= 1'h1;
      rd(8'h28);
      chk(d, 32'h0);
      $display("done event test done");
      wr(8'h14, 32'h01);
      wr(8'h18, 32'h00);
      f0 = falls;
      drv(8'h00, 8'h01, 8'h01);
      chk(32'(irq_wire), 32'h0);
      rd(8'h20);
      chk(d, 32'h01);
      chk(32'(line_r), 32'h0);
      rd(8'h24);
      chk(d, 32'h00);
      chk(32'(line_r), 32'h1);
      drv(8'h00, 8'h03, 8'h01);
      chk(32'(irq_wire), 32'h1);
      drv(8'h00, 8'h00, 8'h00);
      chk(32'(irq_wire), 32'h0);
      rd(8'h24);
      chk(32'(line_r), 32'h0);
      rd(8'h20);
      chk(d, 32'h00);
      chk(32'(line_r), 32'h1);
      chk(32'(falls - f0), 32'h2);
      wr(8'h18, 32'h04);
      drv(8'h00, 8'h00, 8'h04);
      chk(32'(irq_wire), 32'h0);
      rd(8'h24);
      chk(d, 32'h04);
      rd(8'h20);
      chk(32'(line_r), 32'h1);
      $display("threshold test done");
      report_and_stop();
   end
endmodule

bind touch_sense_irq_logic touch_irq_props props (.aclk(aclk),
   .aresetn(aresetn), .clk_en(clk_en), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .stage_done(stage_done),
   .low_active(low_active), .high_active(high_active),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
